// ==== msrb_pkg.sv ====
// Shared constants, types and helpers for the motor set-point register bank
package msrb_pkg;

  // ==========================================================================
  // Geometry
  localparam int WORD_W = 12;
  localparam int NUM_REGS = 6;
  localparam int NUM_POTS = 4;

  // ==========================================================================
  // Register indices, read codes and the write flag
  localparam logic [2:0] IDX_SPEED = 3'h0;
  localparam logic [2:0] IDX_DRIVE = 3'h1;
  localparam logic [2:0] IDX_REGEN = 3'h2;
  localparam logic [2:0] IDX_RISE = 3'h3;
  localparam logic [2:0] IDX_FALL = 3'h4;
  localparam logic [2:0] IDX_TRIP = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam logic [5:0] RD_SPEED = 6'h00;
  localparam logic [5:0] RD_DRIVE = 6'h02;
  localparam logic [5:0] RD_REGEN = 6'h03;
  localparam logic [5:0] RD_RISE = 6'h04;
  localparam logic [5:0] RD_FALL = 6'h05;
  localparam logic [5:0] RD_TRIP = 6'h06;
  localparam int WR_FLAG_BIT = 6;
  localparam int ADDR_FLAG_BIT = 7;
  localparam logic [7:0] NACK_FLAG = 8'h80;
  localparam logic [6:0] CHECK_MASK = 7'h7f;

  // ==========================================================================
  // Reset values and output scaling
  localparam logic [WORD_W-1:0] REG_RESET = 12'h000;
  localparam logic [18:0] DUTY_NUM = 19'h00061;
  localparam logic [18:0] DUTY_DEN = 19'h00064;

  // ==========================================================================
  // Ramp timing: a full-scale ramp of 4096 code steps takes one ramp unit per unit of ramp time
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_UNIT_NS = 10000000;
  localparam int RAMP_STEPS = 4096;
  localparam int RAMP_STEP_NS = RAMP_UNIT_NS / RAMP_STEPS;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RAMP_STEP_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_D1 = 3'b010,
    ST_D2 = 3'b011,
    ST_CHK = 3'b100
  } msrb_fsm_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } msrb_byte_t;

  // ==========================================================================
  // Helpers
  function automatic logic [2:0] msrb_cmd_index(input logic [5:0] code);
    case (code)
      RD_SPEED: msrb_cmd_index = IDX_SPEED;
      RD_DRIVE: msrb_cmd_index = IDX_DRIVE;
      RD_REGEN: msrb_cmd_index = IDX_REGEN;
      RD_RISE: msrb_cmd_index = IDX_RISE;
      RD_FALL: msrb_cmd_index = IDX_FALL;
      RD_TRIP: msrb_cmd_index = IDX_TRIP;
      default: msrb_cmd_index = IDX_NONE;
    endcase
  endfunction : msrb_cmd_index

  function automatic logic [6:0] msrb_check(input logic [7:0] c, input logic [7:0] a,
                                            input logic [7:0] b);
    logic [6:0] sum;
    sum = c[6:0] + a[6:0] + b[6:0];
    msrb_check = sum & CHECK_MASK;
  endfunction : msrb_check

endpackage : msrb_pkg

// ==== msrb_ramp.sv ====
// Rate limiter that walks the applied level toward the speed set-point
`timescale 1ns/1ps
`default_nettype none
module msrb_ramp
  import msrb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic stepTick,
  input wire logic [WORD_W-1:0] target,
  input wire logic [WORD_W-1:0] riseTime,
  input wire logic [WORD_W-1:0] fallTime,
  input wire logic fallEnable,
  output logic [WORD_W-1:0] level
);

  typedef struct packed {
    logic [WORD_W-1:0] level;
    logic [WORD_W-1:0] cnt;
  } msrb_ramp_st_t;

  msrb_ramp_st_t cur_ff;
  msrb_ramp_st_t nxt_cur;
  logic [WORD_W-1:0] period;
  logic rising;

  assign level = cur_ff.level;

  // ==========================================================================
  // Stepping
  always_comb
  begin
    nxt_cur = cur_ff;
    rising = target > cur_ff.level;
    period = rising ? riseTime : fallTime;
    if (target == cur_ff.level)
    begin
      nxt_cur.cnt = '0;
    end
    else if (!rising && !fallEnable)
    begin
      // Falling limit off: follow immediately
      nxt_cur.level = target; // RULE16
    end
    else if (period == '0)
    begin
      nxt_cur.level = target;
    end
    else if (stepTick)
    begin
      if (cur_ff.cnt >= period - 12'h001)
      begin
        nxt_cur.cnt = '0;
        nxt_cur.level = rising ? cur_ff.level + 12'h001 : cur_ff.level - 12'h001; // RULE14
      end
      else
      begin
        nxt_cur.cnt = cur_ff.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  chk_ramp_single_step: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    ($past(riseTime) != '0 && $past(target) > $past(cur_ff.level)) |->
    (cur_ff.level - $past(cur_ff.level) <= 12'h001))
    else $error("ramp rose faster than one code per step");

endmodule : msrb_ramp
`default_nettype wire

// ==== msrb_top.sv ====
// Serial-command register bank for motor set-points, limits and undervoltage trip
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: Speed written by 0x40, read by 0x00
// RULE2: Twelve-bit speed, 4095 means 97 percent duty
// RULE3: Speed follows speed input, through ramps
// RULE4: Changed speed input overwrites a written speed
// RULE5: Speed lock stops speed input overwriting
// RULE6: Values reset at restart, kept only by saving
// RULE7: Duty reduced by current limit and regen
// RULE8: Drive limit written 0x42, read 0x02
// RULE9: Drive limit from pot, overridable, lockable
// RULE10: Drive limit accepts codes 0 to 4095
// RULE11: Regen limit written 0x43, read 0x03
// RULE12: Regen limit from pot, overridable, lockable
// RULE13: Rise ramp written 0x44, read 0x04
// RULE14: Rise ramp sets climb rate, pot backed
// RULE15: Fall ramp written 0x45, read 0x05
// RULE16: Fall ramp sets descent rate, off by default
// RULE17: Master never writes fall ramp below one
// RULE18: Trip level written 0x46, read 0x06
// RULE19: Low supply shuts down once written, locked
// RULE20: Low supply shutdown reported as status
// RULE21: Address bytes have MSB set, others clear
// RULE22: Check byte is byte sum masked 0x7f
// RULE23: Write answered with address, bad check adds 0x80
// RULE24: Read answered with two data, one check
// RULE25: Value split bits 13:7 then 6:0
module msrb_top
  import msrb_pkg::*;
#(
  parameter int STEP_CYC = RAMP_STEP_CYC
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [6:0] ownAddr,
  input wire msrb_byte_t rxByte,
  output msrb_byte_t txByte,
  input wire logic txReady,
  input wire logic [NUM_POTS-1:0][WORD_W-1:0] potSample,
  input wire logic [NUM_REGS-1:0] lockBits,
  input wire logic [WORD_W-1:0] supplyLevel,
  input wire logic [WORD_W-1:0] loadCurrent,
  input wire logic regenActive,
  output logic [NUM_REGS-1:0][WORD_W-1:0] regValues,
  output logic [WORD_W-1:0] dutyCode,
  output logic lowSupplyShutdown,
  output logic lowSupplyEvent
);

  typedef struct packed {
    msrb_fsm_t fsm;
    logic selected;
    logic [7:0] cmd;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [NUM_REGS-1:0][WORD_W-1:0] regs;
    logic [NUM_POTS-1:0][WORD_W-1:0] potRef;
    logic loaded;
    logic tripArmed;
    logic [2:0][7:0] txq;
    logic [1:0] txCnt;
    logic lowSupply;
    logic lowEvent;
    logic [WORD_W-1:0] duty;
    logic [15:0] tick;
  } msrb_state_t;

  msrb_state_t st_ff;
  msrb_state_t nxt_st;

  logic stepTick;
  logic [WORD_W-1:0] rampLevel;
  logic fallEnable;
  logic tripActive;
  logic wrGood;
  logic wrBad;
  logic rdHit;
  logic [2:0] idx;
  logic [7:0] rdD1;
  logic [7:0] rdD2;
  logic [18:0] dutyFull;

  // ==========================================================================
  // Output level shaping
  // Zero fall time turns the falling limit off; master keeps it at one or more
  assign fallEnable = st_ff.regs[IDX_FALL] != '0; // RULE16 RULE17
  assign stepTick = st_ff.tick == 16'(STEP_CYC - 1);
  assign tripActive = st_ff.tripArmed && lockBits[IDX_TRIP]; // RULE19

  msrb_ramp u_ramp (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .stepTick(stepTick),
    .target(st_ff.regs[IDX_SPEED]),
    .riseTime(st_ff.regs[IDX_RISE]),
    .fallTime(st_ff.regs[IDX_FALL]),
    .fallEnable(fallEnable),
    .level(rampLevel)
  );

  assign regValues = st_ff.regs;
  assign dutyCode = st_ff.duty;
  assign lowSupplyShutdown = st_ff.lowSupply;
  assign lowSupplyEvent = st_ff.lowEvent;
  assign txByte.valid = st_ff.txCnt != 2'h0;
  assign txByte.data = st_ff.txq[0];

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    wrGood = 1'b0;
    wrBad = 1'b0;
    rdHit = 1'b0;
    idx = msrb_cmd_index(st_ff.cmd[5:0]);
    rdD1 = 8'h00;
    rdD2 = 8'h00;
    nxt_st.lowEvent = 1'b0;
    nxt_st.tick = stepTick ? 16'h0000 : st_ff.tick + 16'h0001;

    // Potentiometer tracking; a moved pot wins unless its lock is set or a good write to that register completes in the same cycle
    for (int i = 0; i < NUM_POTS; i++)
    begin
      if (!st_ff.loaded)
      begin
        nxt_st.regs[i] = potSample[i]; // RULE3
        nxt_st.potRef[i] = potSample[i];
      end
      else if (potSample[i] != st_ff.potRef[i])
      begin
        nxt_st.potRef[i] = potSample[i];
        if (!lockBits[i])
        begin
          nxt_st.regs[i] = potSample[i]; // RULE4 RULE5 RULE9 RULE12 RULE14
        end
      end
    end
    nxt_st.loaded = 1'b1;

    // Reply bytes drain one per accepted handshake
    if (txByte.valid && txReady)
    begin
      nxt_st.txq = {8'h00, st_ff.txq[2:1]};
      nxt_st.txCnt = st_ff.txCnt - 2'h1;
    end

    // Frame decoding
    if (rxByte.valid)
    begin
      if (rxByte.data[ADDR_FLAG_BIT])
      begin
        nxt_st.selected = rxByte.data[6:0] == ownAddr; // RULE21
        nxt_st.fsm = (rxByte.data[6:0] == ownAddr) ? ST_CMD : ST_IDLE;
      end
      else
      begin
        case (st_ff.fsm)
          ST_IDLE:
          begin
            nxt_st.fsm = ST_IDLE;
          end
          ST_CMD:
          begin
            nxt_st.cmd = rxByte.data;
            idx = msrb_cmd_index(rxByte.data[5:0]);
            if (rxByte.data[WR_FLAG_BIT])
            begin
              nxt_st.fsm = ST_D1;
            end
            else if (idx != IDX_NONE)
            begin
              // Value bits 13:12 are always zero for twelve-bit fields
              rdHit = 1'b1;
              rdD1 = {3'b000, st_ff.regs[idx][11:7]}; // RULE25
              rdD2 = {1'b0, st_ff.regs[idx][6:0]};
              nxt_st.txq = {{1'b0, msrb_check(rxByte.data, rdD1, rdD2)}, rdD2, rdD1}; // RULE24
              nxt_st.txCnt = 2'h3;
            end
          end
          ST_D1:
          begin
            nxt_st.d1 = rxByte.data;
            nxt_st.fsm = ST_D2;
          end
          ST_D2:
          begin
            nxt_st.d2 = rxByte.data;
            nxt_st.fsm = ST_CHK;
          end
          ST_CHK:
          begin
            nxt_st.fsm = ST_CMD;
            nxt_st.txCnt = 2'h1;
            if (rxByte.data[6:0] == msrb_check(st_ff.cmd, st_ff.d1, st_ff.d2)) // RULE22
            begin
              wrGood = 1'b1;
              nxt_st.txq = {16'h0000, 1'b0, ownAddr}; // RULE23
              if (idx != IDX_NONE)
              begin
                // Bits 13:12 fall outside the field and are dropped
                nxt_st.regs[idx] = {st_ff.d1[4:0], st_ff.d2[6:0]}; // RULE1 RULE8 RULE10 RULE11 RULE13 RULE15 RULE18 RULE25
                if (idx < 3'(NUM_POTS))
                begin
                  nxt_st.potRef[idx] = potSample[idx]; // RULE4
                end
                if (idx == IDX_TRIP)
                begin
                  nxt_st.tripArmed = 1'b1; // RULE19
                end
              end
            end
            else
            begin
              wrBad = 1'b1;
              nxt_st.txq = {16'h0000, NACK_FLAG | {1'b0, ownAddr}}; // RULE23
            end
          end
          default:
          begin
            nxt_st.fsm = ST_IDLE;
          end
        endcase
      end
    end

    // Undervoltage trip, reported on entry
    nxt_st.lowSupply = tripActive && (supplyLevel < st_ff.regs[IDX_TRIP]); // RULE19
    nxt_st.lowEvent = nxt_st.lowSupply && !st_ff.lowSupply; // RULE20

    // Duty: 4095 maps to 97 percent of full scale, then the limiters
    dutyFull = (19'(rampLevel) * DUTY_NUM) / DUTY_DEN; // RULE2
    if (st_ff.lowSupply || regenActive)
    begin
      nxt_st.duty = '0; // RULE7
    end
    else if (loadCurrent > st_ff.regs[IDX_DRIVE])
    begin
      nxt_st.duty = dutyFull[12:1]; // RULE7
    end
    else
    begin
      nxt_st.duty = dutyFull[11:0];
    end
  end

  // ==========================================================================
  // State register; nothing survives a restart
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0; // RULE6
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Checks
  chk_write_ack_addr: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE23
    wrGood |=> (txByte.valid && txByte.data == {1'b0, ownAddr} && st_ff.txCnt == 2'h1))
    else $error("good write not answered with own address");

  chk_write_nack_addr: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE23
    wrBad |=> (txByte.data == (NACK_FLAG | {1'b0, ownAddr})))
    else $error("bad check not answered with flagged address");

  chk_read_three_bytes: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE24
    (rdHit && !txReady) |=> (st_ff.txCnt == 2'h3 && txByte.data[7:5] == 3'b000))
    else $error("read did not queue three bytes");

  chk_reply_check_byte: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE22
    rdHit |=> (st_ff.txq[2] ==
      {1'b0, msrb_check($past(rxByte.data), st_ff.txq[0], st_ff.txq[1])}))
    else $error("read check byte wrong");

  // Unknown read codes and foreign frames must leave the reply line quiet
  chk_unknown_read_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE24
    (st_ff.fsm == ST_CMD && rxByte.valid && rxByte.data[7:6] == 2'b00 &&
     msrb_cmd_index(rxByte.data[5:0]) == IDX_NONE && !txByte.valid) |=> !txByte.valid)
    else $error("unknown read code answered");

  chk_unselected_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE21
    (!st_ff.selected && rxByte.valid && !rxByte.data[ADDR_FLAG_BIT] && !txByte.valid) |=>
    !txByte.valid)
    else $error("unselected device answered a byte");

  chk_lock_holds_speed: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE5
    (st_ff.loaded && lockBits[IDX_SPEED] && !wrGood) |=>
    (st_ff.regs[IDX_SPEED] == $past(st_ff.regs[IDX_SPEED])))
    else $error("locked speed changed without a write");

  chk_pot_overwrite: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
    (st_ff.loaded && !lockBits[IDX_DRIVE] && !wrGood &&
     potSample[IDX_DRIVE] != st_ff.potRef[IDX_DRIVE]) |=>
    (st_ff.regs[IDX_DRIVE] == $past(potSample[IDX_DRIVE])))
    else $error("moved pot did not overwrite drive limit");

  chk_fall_immediate: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE16
    (!fallEnable && st_ff.regs[IDX_SPEED] < rampLevel) |=>
    (rampLevel == $past(st_ff.regs[IDX_SPEED])))
    else $error("disabled fall ramp did not follow at once");

  chk_trip_shutdown: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE19
    (tripActive && supplyLevel < st_ff.regs[IDX_TRIP]) |=> lowSupplyShutdown)
    else $error("low supply not shut down");

  chk_trip_idle_unarmed: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE19
    !st_ff.tripArmed |=> !lowSupplyShutdown)
    else $error("trip acted before being written");

  chk_trip_needs_lock: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE19
    !lockBits[IDX_TRIP] |=> !lowSupplyShutdown)
    else $error("trip acted while unlocked");

  chk_low_event_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE20
    $rose(lowSupplyShutdown) |-> (lowSupplyEvent ##1 !lowSupplyEvent))
    else $error("low supply status not reported once");

  chk_regen_zero_duty: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
    regenActive |=> (dutyCode == '0))
    else $error("duty not cut during regen");

  chk_over_current_half: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
    (loadCurrent > st_ff.regs[IDX_DRIVE]) |=> (dutyCode <= 12'h7c2))
    else $error("over current did not halve duty");

  chk_full_scale_duty: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
    (rampLevel == 12'hfff && !regenActive && !st_ff.lowSupply &&
     loadCurrent <= st_ff.regs[IDX_DRIVE]) |=> (dutyCode == 12'hf84))
    else $error("full speed is not 97 percent duty");

  cov_good_write: cover property (@(posedge clk_sys) disable iff (!arst_n) wrGood);
  cov_bad_write: cover property (@(posedge clk_sys) disable iff (!arst_n) wrBad);
  cov_read_reply: cover property (@(posedge clk_sys) disable iff (!arst_n)
    rdHit ##[1:20] (st_ff.txCnt == 2'h0));
  cov_trip: cover property (@(posedge clk_sys) disable iff (!arst_n) lowSupplyEvent);
  cov_foreign_byte: cover property (@(posedge clk_sys) disable iff (!arst_n)
    !st_ff.selected && rxByte.valid && !rxByte.data[ADDR_FLAG_BIT]);

endmodule : msrb_top
`default_nettype wire

// ==== msrb_host_model.sv ====
// Serial bus master model: frames commands and collects replies
`timescale 1ns/1ps
`default_nettype none
module msrb_host_model
  import msrb_pkg::*;
(
  input wire logic clk_sys,
  output var msrb_byte_t rxByte,
  input wire msrb_byte_t txByte,
  output logic txReady
);
  int stall;

  initial
  begin
    stall = 0;
    rxByte = '0;
    txReady = 1'b0;
  end

  // ==========================================================================
  // Byte level
  task automatic sendByte(input logic [7:0] b);
    @(posedge clk_sys);
    #1;
    rxByte = '{valid: 1'b1, data: b};
    @(posedge clk_sys);
    #1;
    // Released data shows the inverse so a stale byte never looks valid
    rxByte = '{valid: 1'b0, data: ~b};
  endtask : sendByte

  task automatic getByte(output logic [7:0] b);
    int n;
    n = 0;
    while (txByte.valid !== 1'b1 && n < 60)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    repeat (stall) @(posedge clk_sys);
    #1;
    txReady = 1'b1;
    // Take the byte while it stands, ahead of the accepting edge
    @(negedge clk_sys);
    b = txByte.data;
    @(posedge clk_sys);
    #1;
    txReady = 1'b0;
  endtask : getByte

  // ==========================================================================
  // Frames
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [11:0] v,
                    input logic bad, output logic [7:0] ack);
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] ck;
    if (cmd == 8'h45 && v == 12'h000) v = 12'h001;
    d1 = {3'h0, v[11:7]};
    d2 = {1'b0, v[6:0]};
    ck = (cmd + d1 + d2) & 8'h7f;
    sendByte({1'b1, a});
    sendByte(cmd);
    sendByte(d1);
    sendByte(d2);
    sendByte(ck ^ {7'h0, bad});
    getByte(ack);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] cmd, output logic [23:0] r);
    sendByte({1'b1, a});
    sendByte(cmd);
    getByte(r[23:16]);
    getByte(r[15:8]);
    getByte(r[7:0]);
  endtask : rd
endmodule : msrb_host_model
`default_nettype wire

// ==== msrb_top_tb_top.sv ====
// Self-checking bench for the motor set-point register bank
`timescale 1ns/1ps
`default_nettype none
module msrb_top_tb_top
  import msrb_pkg::*;
;
  localparam logic [7:0] WCMD [6] = '{8'h40, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
  localparam logic [11:0] WVAL [6] = '{12'hfff, 12'h000, 12'h5a5, 12'h000, 12'h001, 12'h123};
  localparam logic [11:0] FULL = 12'(4095 * 97 / 100);
  localparam logic [11:0] HALF = 12'(4095 * 97 / 100 / 2);
  logic clk_sys;
  logic arst_n;
  logic [6:0] ownAddr;
  msrb_byte_t rxByte;
  msrb_byte_t txByte;
  logic txReady;
  logic [NUM_POTS-1:0][WORD_W-1:0] pots;
  logic [NUM_REGS-1:0] lockBits;
  logic [WORD_W-1:0] supplyLevel;
  logic [WORD_W-1:0] loadCurrent;
  logic regenActive;
  logic [NUM_REGS-1:0][WORD_W-1:0] regValues;
  logic [WORD_W-1:0] dutyCode;
  logic lowSupplyShutdown;
  logic lowSupplyEvent;
  int badCount;
  int totalChecks;

  msrb_top #(.STEP_CYC(2)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .ownAddr(ownAddr),
    .rxByte(rxByte), .txByte(txByte), .txReady(txReady), .potSample(pots),
    .lockBits(lockBits), .supplyLevel(supplyLevel), .loadCurrent(loadCurrent),
    .regenActive(regenActive), .regValues(regValues), .dutyCode(dutyCode),
    .lowSupplyShutdown(lowSupplyShutdown), .lowSupplyEvent(lowSupplyEvent));

  msrb_host_model host_u (.clk_sys(clk_sys), .rxByte(rxByte), .txByte(txByte),
    .txReady(txReady));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic waitDuty(input logic [11:0] exp, input int lim);
    int n;
    n = 0;
    while (dutyCode !== exp && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask : waitDuty

  task automatic doReset;
    arst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    tick(3);
  endtask : doReset

  task automatic test_done;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Scenarios
  task automatic t_defaults;
    for (int i = 0; i < 4; i++) chk("pot default", pots[i], regValues[i]);
    chk("fall default", 12'h000, regValues[IDX_FALL]);
    chk("trip default", 12'h000, regValues[IDX_TRIP]);
    chk("no shutdown", 12'h000, {11'h0, lowSupplyShutdown});
    $display("t_defaults done");
  endtask : t_defaults

  task automatic t_duty;
    logic [7:0] ack;
    lockBits[0] = 1'b1;
    host_u.wr(ownAddr, 8'h44, 12'h000, 1'b0, ack);
    host_u.wr(ownAddr, 8'h40, 12'hfff, 1'b0, ack);
    waitDuty(FULL, 20);
    chk("full duty", FULL, dutyCode);
    loadCurrent = 12'h101;
    waitDuty(HALF, 20);
    chk("over current", HALF, dutyCode);
    loadCurrent = 12'h000;
    regenActive = 1'b1;
    waitDuty(12'h000, 20);
    chk("regen", 12'h000, dutyCode);
    regenActive = 1'b0;
    waitDuty(FULL, 20);
    host_u.wr(ownAddr, 8'h40, 12'h000, 1'b0, ack);
    waitDuty(12'h000, 20);
    chk("instant fall", 12'h000, dutyCode);
    host_u.wr(ownAddr, 8'h44, 12'h001, 1'b0, ack);
    host_u.wr(ownAddr, 8'h40, 12'hfff, 1'b0, ack);
    tick(100);
    chk("rise slow", 12'h001, {11'h0, dutyCode < FULL});
    waitDuty(FULL, 10000);
    chk("rise end", FULL, dutyCode);
    host_u.wr(ownAddr, 8'h45, 12'h001, 1'b0, ack);
    host_u.wr(ownAddr, 8'h40, 12'h000, 1'b0, ack);
    tick(100);
    chk("fall slow", 12'h001, {11'h0, dutyCode > 12'h000});
    $display("t_duty done");
  endtask : t_duty

  task automatic t_regs;
    logic [7:0] ack;
    logic [23:0] rb;
    for (int i = 0; i < 6; i++)
    begin
      host_u.stall = i % 3;
      host_u.wr(ownAddr, WCMD[i], WVAL[i], 1'b0, ack);
      chk("ack", {5'h0, ownAddr}, {4'h0, ack});
      chk("stored", WVAL[i], regValues[i]);
      host_u.rd(ownAddr, WCMD[i] - 8'h40, rb);
      chk("read value", WVAL[i], {rb[20:16], rb[14:8]});
      chk("read tops", 12'h000, {7'h0, rb[23:21], rb[15], rb[7]});
      chk("read check", {4'h0, rb[23:16] + rb[15:8] + WCMD[i] - 8'h40} & 12'h07f,
          {4'h0, rb[7:0]});
    end
    host_u.stall = 0;
    $display("t_regs done");
  endtask : t_regs

  task automatic t_badsel;
    logic [7:0] ack;
    logic [23:0] rb;
    host_u.wr(ownAddr, 8'h42, 12'h777, 1'b1, ack);
    chk("nack", {5'h01, ownAddr}, {4'h0, ack});
    chk("nack kept", 12'h000, regValues[IDX_DRIVE]);
    host_u.rd(ownAddr, 8'h01, rb);
    chk("unknown read", 12'h000, {11'h0, txByte.valid});
    host_u.wr(ownAddr ^ 7'h01, 8'h42, 12'h777, 1'b0, ack);
    chk("unselected", 12'h000, regValues[IDX_DRIVE]);
    chk("unselected quiet", 12'h000, {11'h0, txByte.valid});
    $display("t_badsel done");
  endtask : t_badsel

  task automatic t_override;
    logic [7:0] ack;
    for (int i = 0; i < 4; i++)
    begin
      lockBits[i] = 1'b0;
      host_u.wr(ownAddr, WCMD[i], 12'h0a5 + 12'(i), 1'b0, ack);
      tick(5);
      chk("held", 12'h0a5 + 12'(i), regValues[i]);
      pots[i] = pots[i] + 12'h011;
      tick(5);
      chk("pot wins", pots[i], regValues[i]);
      lockBits[i] = 1'b1;
      host_u.wr(ownAddr, WCMD[i], 12'h3c3, 1'b0, ack);
      pots[i] = pots[i] + 12'h011;
      tick(5);
      chk("locked", 12'h3c3, regValues[i]);
    end
    $display("t_override done");
  endtask : t_override

  task automatic t_trip;
    int n;
    n = 0;
    supplyLevel = 12'h0ff;
    tick(5);
    chk("unlocked trip", 12'h000, {11'h0, lowSupplyShutdown});
    lockBits[IDX_TRIP] = 1'b1;
    repeat (10)
    begin
      tick(1);
      n += int'(lowSupplyEvent);
    end
    chk("event count", 12'h001, 12'(n));
    chk("shutdown", 12'h001, {11'h0, lowSupplyShutdown});
    chk("duty off", 12'h000, dutyCode);
    supplyLevel = 12'h123;
    tick(5);
    chk("at level", 12'h000, {11'h0, lowSupplyShutdown});
    $display("t_trip done");
  endtask : t_trip

  // ==========================================================================
  // Sequence
  initial
  begin
    arst_n = 1'b0;
    ownAddr = 7'h2a;
    pots = {12'h300, 12'h200, 12'h100, 12'h400};
    lockBits = '0;
    supplyLevel = 12'hfff;
    loadCurrent = 12'h000;
    regenActive = 1'b0;
    badCount = 0;
    totalChecks = 0;
    doReset;
    t_defaults;
    t_duty;
    t_regs;
    t_badsel;
    t_override;
    t_trip;
    lockBits = '0;
    doReset;
    t_defaults;
    test_done;
  end

  initial
  begin
    #500000;
    badCount++;
    test_done;
  end
endmodule : msrb_top_tb_top
`default_nettype wire
